/* rtl/dmag_addr_gen.sv */
`default_nettype none
module dmag_addr_gen #(
  parameter logic [7:0] ACCESS_SPLIT = dmag_pkg::SPLIT_DFLT
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic INSTR_VALID,
  input wire dmag_pkg::dmag_instr_type INSTR,
  input wire logic [7:0] WREG,
  input wire logic [3:0] BUS_ADDR,
  input wire logic [7:0] BUS_WDATA,
  input wire logic BUS_WE,
  input wire logic BUS_RE,
  output logic [7:0] BUS_RDATA,
  output dmag_pkg::dmag_oper_type OPER
);
  localparam int AW = dmag_pkg::ADDR_W;

  // ****************************************
  // software-visible state
  // ****************************************
  logic [dmag_pkg::BANK_W-1:0] bank;
  logic ext_en;
  logic [AW-1:0] ptr [dmag_pkg::NUM_PTR];
  logic [AW-1:0] next_ptr [dmag_pkg::NUM_PTR];
  dmag_pkg::dmag_oper_type dec;
  dmag_pkg::dmag_oper_type next_oper;

  wire wr_bank = BUS_WE && (BUS_ADDR == dmag_pkg::REG_BANK);
  wire wr_cfg = BUS_WE && (BUS_ADDR == dmag_pkg::REG_CFG);

  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      bank <= dmag_pkg::BANK_RST;
      ext_en <= dmag_pkg::CFG_RST;
    end
    else
    begin
      if (wr_bank)
        bank <= BUS_WDATA[dmag_pkg::BANK_W-1:0];
      if (wr_cfg)
        ext_en <= BUS_WDATA[0];
    end
  end

  // ****************************************
  // field extraction
  // ****************************************
  wire [3:0] cls = INSTR.word[dmag_pkg::CLS_LSB +: 4];
  wire [7:0] fadr = INSTR.word[7:0];
  wire acc_bit = INSTR.word[dmag_pkg::A_POS];
  wire dst_bit = INSTR.word[dmag_pkg::D_POS];
  wire [AW-1:0] fadr_w = {4'h0, fadr};
  wire uses_file = (cls == dmag_pkg::CLS_BYTE_D) || (cls == dmag_pkg::CLS_BIT)
                   || (cls == dmag_pkg::CLS_BYTE_F) || (cls == dmag_pkg::CLS_BYTE_W);

  // ****************************************
  // direct and indexed address forming
  // ****************************************
  // split point below which the access region is low RAM
  wire in_low = fadr < ACCESS_SPLIT;
  wire [AW-1:0] access_addr = in_low ? {dmag_pkg::PAGE_LO, fadr} : {dmag_pkg::PAGE_HI, fadr};
  // bank select forms the upper nibble
  wire [AW-1:0] banked_addr = {bank, fadr};
  // offset mode only while the extended set is on
  wire indexed = uses_file && ext_en && !acc_bit && in_low;
  wire [AW-1:0] indexed_addr = ptr[dmag_pkg::INDEX_PTR] + fadr_w;
  wire [AW-1:0] direct_addr = indexed ? indexed_addr : (acc_bit ? banked_addr : access_addr);

  // ****************************************
  // indirect operand decode
  // ****************************************
  // operands sit in groups of eight on the high page, one group per pointer
  wire [7:0] ind_off = direct_addr[7:0] - dmag_pkg::IND_BASE;
  wire [1:0] ind_sel = ind_off[4:3];
  wire [2:0] ind_kind = ind_off[2:0];
  // operand address hits an indirect register
  wire ind_hit = uses_file && !indexed
                 && (direct_addr[AW-1:8] == dmag_pkg::IND_PAGE)
                 && (ind_off[7:5] == 3'h0)
                 && (int'(ind_sel) < dmag_pkg::NUM_PTR)
                 && (ind_kind <= dmag_pkg::KIND_PLUSW);
  wire [AW-1:0] ind_ptr = ptr[ind_sel];
  wire [AW-1:0] ind_inc = ind_ptr + 12'h001;
  wire [AW-1:0] ind_dec = ind_ptr - 12'h001;
  // offset by the working register, sign extended
  wire [AW-1:0] ind_plusw = ind_ptr + {{4{WREG[7]}}, WREG};
  wire [AW-1:0] ind_addr = (ind_kind == dmag_pkg::KIND_PREINC) ? ind_inc
                         : (ind_kind == dmag_pkg::KIND_PLUSW) ? ind_plusw
                         : ind_ptr;
  wire [AW-1:0] file_addr = ind_hit ? ind_addr : direct_addr;
  // a file operand takes one of its possible modes
  wire dmag_pkg::dmag_mode_type file_mode = ind_hit ? dmag_pkg::MODE_INDIRECT
                                          : indexed ? dmag_pkg::MODE_INDEXED
                                          : acc_bit ? dmag_pkg::MODE_BANKED
                                          : dmag_pkg::MODE_ACCESS;

  // ****************************************
  // pointer update
  // ****************************************
  // pointer side effect of an indirect access
  wire upd_en = INSTR_VALID && ind_hit
                && ((ind_kind == dmag_pkg::KIND_POSTINC)
                || (ind_kind == dmag_pkg::KIND_POSTDEC)
                || (ind_kind == dmag_pkg::KIND_PREINC));
  wire [AW-1:0] upd_val = (ind_kind == dmag_pkg::KIND_POSTDEC) ? ind_dec : ind_inc;

  genvar gi;
  generate
    for (gi = 0; gi < dmag_pkg::NUM_PTR; gi++)
    begin : g_ptr
      localparam logic [3:0] LO_IDX = 4'(dmag_pkg::REG_PTR_BASE + 2 * gi);
      localparam logic [3:0] HI_IDX = 4'(dmag_pkg::REG_PTR_BASE + 2 * gi + 1);
      wire wr_lo = BUS_WE && (BUS_ADDR == LO_IDX);
      wire wr_hi = BUS_WE && (BUS_ADDR == HI_IDX);
      wire hit = upd_en && (int'(ind_sel) == gi);
      // a software write beats the auto-update in the same cycle
      assign next_ptr[gi] = wr_lo ? {ptr[gi][AW-1:8], BUS_WDATA}
                          : wr_hi ? {BUS_WDATA[3:0], ptr[gi][7:0]}
                          : hit ? upd_val
                          : ptr[gi];
      always_ff @(posedge SYS_CLK or posedge RST)
      begin
        if (RST)
          ptr[gi] <= dmag_pkg::PTR_RST;
        else
          ptr[gi] <= next_ptr[gi];
      end
    end
  endgenerate

  // ****************************************
  // instruction decode
  // ****************************************
  // data addresses are formed here; the branch class also assembles its target into the literal field
  always_comb
  begin
    dec = '0;
    dec.valid = 1'b1;
    dec.mode = dmag_pkg::MODE_INHERENT;
    unique case (cls)
      dmag_pkg::CLS_INHERENT:
      begin
        dec.mode = dmag_pkg::MODE_INHERENT;
      end
      // constant goes to the working register
      dmag_pkg::CLS_LITERAL:
      begin
        dec.mode = dmag_pkg::MODE_LITERAL;
        dec.lit = {12'h000, fadr};
        dec.dest_w = 1'b1;
      end
      dmag_pkg::CLS_BRANCH:
      begin
        dec.mode = dmag_pkg::MODE_LITERAL;
        dec.lit = {INSTR.ext[AW-1:0], fadr};
      end
      dmag_pkg::CLS_BYTE_D:
      begin
        dec.mode = file_mode;
        dec.src = file_addr;
        dec.dest_w = !dst_bit;
        dec.wr_file = dst_bit;
        dec.dst = dst_bit ? file_addr : 12'h000;
      end
      // implied destination is the file register
      dmag_pkg::CLS_BIT, dmag_pkg::CLS_BYTE_F:
      begin
        dec.mode = file_mode;
        dec.src = file_addr;
        dec.dst = file_addr;
        dec.wr_file = 1'b1;
      end
      // implied destination is the working register
      dmag_pkg::CLS_BYTE_W:
      begin
        dec.mode = file_mode;
        dec.src = file_addr;
        dec.dest_w = 1'b1;
      end
      dmag_pkg::CLS_FULL_MOVE:
      begin
        dec.mode = dmag_pkg::MODE_FULL;
        dec.src = INSTR.word[AW-1:0];
        dec.dst = INSTR.ext[AW-1:0];
        dec.wr_file = 1'b1;
      end
      // unused class codes behave as inherent
      default:
      begin
        dec.mode = dmag_pkg::MODE_INHERENT;
      end
    endcase
  end

  // fields hold while idle so status readback shows the last operand
  always_comb
  begin
    next_oper = INSTR_VALID ? dec : OPER;
    next_oper.valid = INSTR_VALID;
  end

  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
      OPER <= '0;
    else
      OPER <= next_oper;
  end

  // ****************************************
  // register read port
  // ****************************************
  wire [3:0] ptr_off = BUS_ADDR - dmag_pkg::REG_PTR_BASE;
  wire rd_is_ptr = (BUS_ADDR >= dmag_pkg::REG_PTR_BASE) && (int'(ptr_off[3:1]) < dmag_pkg::NUM_PTR);
  wire [AW-1:0] rd_ptr = ptr[ptr_off[2:1]];
  wire [7:0] rd_ptr_byte = ptr_off[0] ? {4'h0, rd_ptr[AW-1:8]} : rd_ptr[7:0];
  wire [7:0] rd_status = {3'h0, OPER.wr_file, OPER.dest_w, OPER.mode};
  wire [7:0] rd_val = (BUS_ADDR == dmag_pkg::REG_BANK) ? {4'h0, bank}
                    : (BUS_ADDR == dmag_pkg::REG_CFG) ? {7'h00, ext_en}
                    : (BUS_ADDR == dmag_pkg::REG_STATUS) ? rd_status
                    : rd_is_ptr ? rd_ptr_byte
                    : 8'h00;

  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
      BUS_RDATA <= 8'h00;
    else
      BUS_RDATA <= BUS_RE ? rd_val : 8'h00;
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);

  chk_banked_addr: assert property (
    (INSTR_VALID && uses_file && acc_bit && !ind_hit)
    |=> (OPER.mode == dmag_pkg::MODE_BANKED) && (OPER.src == {$past(bank), $past(fadr)}))
    else $error("banked address not formed from bank select");

  chk_access_map: assert property (
    (INSTR_VALID && uses_file && !acc_bit && !indexed && !ind_hit)
    |=> (OPER.mode == dmag_pkg::MODE_ACCESS)
        && (OPER.src[AW-1:8] == ($past(in_low) ? dmag_pkg::PAGE_LO : dmag_pkg::PAGE_HI)))
    else $error("access region mapping wrong");

  chk_full_move: assert property (
    (INSTR_VALID && cls == dmag_pkg::CLS_FULL_MOVE)
    |=> (OPER.src == $past(INSTR.word[AW-1:0])) && (OPER.dst == $past(INSTR.ext[AW-1:0])))
    else $error("full move addresses altered");

  chk_dest_file: assert property (
    (INSTR_VALID && cls == dmag_pkg::CLS_BYTE_D && dst_bit)
    |=> OPER.wr_file && !OPER.dest_w && (OPER.dst == OPER.src))
    else $error("result not written back to source");

  chk_dest_w: assert property (
    (INSTR_VALID && cls == dmag_pkg::CLS_BYTE_D && !dst_bit)
    |=> OPER.dest_w && !OPER.wr_file)
    else $error("result not sent to working register");

  chk_indexed_gate: assert property (
    (OPER.valid && OPER.mode == dmag_pkg::MODE_INDEXED) |-> $past(ext_en))
    else $error("indexed mode while extended set off");

  chk_indirect_addr: assert property (
    (INSTR_VALID && ind_hit && ind_kind == dmag_pkg::KIND_PLAIN)
    |=> (OPER.mode == dmag_pkg::MODE_INDIRECT) && (OPER.src == $past(ind_ptr)))
    else $error("indirect address not from pointer");

  chk_ptr_postinc: assert property (
    (upd_en && ind_kind == dmag_pkg::KIND_POSTINC && !BUS_WE)
    |=> (ptr[$past(ind_sel)] == $past(ind_ptr) + 12'h001)
        && (OPER.src == $past(ind_ptr)))
    else $error("post-increment pointer wrong");

  chk_ptr_postdec: assert property (
    (upd_en && ind_kind == dmag_pkg::KIND_POSTDEC && !BUS_WE)
    |=> ptr[$past(ind_sel)] == $past(ind_ptr) - 12'h001)
    else $error("post-decrement pointer wrong");

  chk_branch_lit: assert property (
    (INSTR_VALID && cls == dmag_pkg::CLS_BRANCH)
    |=> OPER.lit == {$past(INSTR.ext[AW-1:0]), $past(fadr)})
    else $error("branch target not assembled");

  chk_ptr_read: assert property (
    (BUS_RE && BUS_ADDR == dmag_pkg::REG_PTR_BASE)
    |=> BUS_RDATA == $past(ptr[0][7:0]) ##1 (BUS_RDATA == 8'h00 || $past(BUS_RE)))
    else $error("pointer readback wrong");

  chk_inherent_none: assert property (
    (INSTR_VALID && cls == dmag_pkg::CLS_INHERENT)
    |=> (OPER.mode == dmag_pkg::MODE_INHERENT) && (OPER.src == 12'h000) && (OPER.dst == 12'h000)
        && !OPER.wr_file && !OPER.dest_w)
    else $error("inherent instruction produced an operand");

  chk_literal_const: assert property (
    (INSTR_VALID && cls == dmag_pkg::CLS_LITERAL)
    |=> (OPER.mode == dmag_pkg::MODE_LITERAL) && OPER.dest_w && (OPER.lit == {12'h000, $past(fadr)}))
    else $error("literal constant not passed");

  chk_indexed_addr: assert property (
    (INSTR_VALID && uses_file && ext_en && !acc_bit && in_low)
    |=> (OPER.mode == dmag_pkg::MODE_INDEXED)
        && (OPER.src == $past(ptr[dmag_pkg::INDEX_PTR]) + {4'h0, $past(fadr)}))
    else $error("indexed address not pointer plus offset");

  chk_ptr_preinc: assert property (
    (upd_en && ind_kind == dmag_pkg::KIND_PREINC && !BUS_WE)
    |=> (ptr[$past(ind_sel)] == $past(ind_ptr) + 12'h001)
        && (OPER.src == $past(ind_ptr) + 12'h001))
    else $error("pre-increment pointer wrong");

  chk_ptr_plusw: assert property (
    (INSTR_VALID && ind_hit && ind_kind == dmag_pkg::KIND_PLUSW && !BUS_WE)
    |=> (ptr[$past(ind_sel)] == $past(ind_ptr))
        && (OPER.src == $past(ind_ptr) + {{4{$past(WREG[7])}}, $past(WREG)}))
    else $error("offset operand address or pointer wrong");

  chk_rdata_idle: assert property (
    !BUS_RE |=> (BUS_RDATA == 8'h00))
    else $error("read data present without a read");
endmodule : dmag_addr_gen
`default_nettype wire

/* rtl/dmag_pkg.sv */
`default_nettype none
package dmag_pkg;
  localparam int ADDR_W = 12;
  localparam int FILE_W = 8;
  localparam int BANK_W = 4;
  localparam int LIT_W = 20;
  localparam int WORD_W = 16;
  localparam int NUM_PTR = 3;
  localparam int CLS_LSB = 12;
  localparam int D_POS = 9;
  localparam int A_POS = 8;
  localparam int INDEX_PTR = 2;
  // ****************************************
  // instruction classes (word[15:12])
  // ****************************************
  localparam logic [3:0] CLS_INHERENT = 4'h0;
  localparam logic [3:0] CLS_LITERAL = 4'h1;
  localparam logic [3:0] CLS_BRANCH = 4'h2;
  localparam logic [3:0] CLS_BYTE_D = 4'h3;
  localparam logic [3:0] CLS_BIT = 4'h4;
  localparam logic [3:0] CLS_FULL_MOVE = 4'h5;
  localparam logic [3:0] CLS_BYTE_F = 4'h6;
  localparam logic [3:0] CLS_BYTE_W = 4'h7;
  // ****************************************
  // register port map and reset values
  // ****************************************
  localparam logic [3:0] REG_BANK = 4'h0;
  localparam logic [3:0] REG_CFG = 4'h1;
  localparam logic [3:0] REG_PTR_BASE = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] BANK_RST = 4'h0;
  localparam logic CFG_RST = 1'b0;
  localparam logic [11:0] PTR_RST = 12'h000;
  // ****************************************
  // data memory layout
  // ****************************************
  localparam logic [7:0] SPLIT_DFLT = 8'h60;
  localparam logic [3:0] PAGE_LO = 4'h0;
  localparam logic [3:0] PAGE_HI = 4'hf;
  localparam logic [3:0] IND_PAGE = 4'hf;
  localparam logic [7:0] IND_BASE = 8'hd0;
  localparam logic [2:0] KIND_PLAIN = 3'h0;
  localparam logic [2:0] KIND_POSTINC = 3'h1;
  localparam logic [2:0] KIND_POSTDEC = 3'h2;
  localparam logic [2:0] KIND_PREINC = 3'h3;
  localparam logic [2:0] KIND_PLUSW = 3'h4;
  typedef enum logic [2:0] {
    MODE_INHERENT = 3'b000,
    MODE_LITERAL = 3'b001,
    MODE_BANKED = 3'b010,
    MODE_ACCESS = 3'b011,
    MODE_INDIRECT = 3'b100,
    MODE_INDEXED = 3'b101,
    MODE_FULL = 3'b110
  } dmag_mode_type;
  typedef struct packed {
    logic [WORD_W-1:0] word;
    logic [WORD_W-1:0] ext;
  } dmag_instr_type;
  typedef struct packed {
    logic valid;
    dmag_mode_type mode;
    logic [ADDR_W-1:0] src;
    logic [ADDR_W-1:0] dst;
    logic dest_w;
    logic wr_file;
    logic [LIT_W-1:0] lit;
  } dmag_oper_type;
endpackage : dmag_pkg
`default_nettype wire

/* testbench/tb_data_memory_address_generation.sv */
`default_nettype none
module tb_data_memory_address_generation;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic instr_valid = 1'b0;
  dmag_pkg::dmag_instr_type instr = '0;
  logic [7:0] wreg = 8'h00;
  logic [3:0] bus_addr = 4'h0;
  logic [7:0] bus_wdata = 8'h00;
  logic bus_we = 1'b0;
  logic bus_re = 1'b0;
  logic [7:0] bus_rdata;
  dmag_pkg::dmag_oper_type oper;
  int bad_count = 0;
  int samples_checked = 0;

  dmag_addr_gen #(.ACCESS_SPLIT(8'h60)) u_dmag_addr_gen (
    .SYS_CLK(sys_clk),
    .RST(rst),
    .INSTR_VALID(instr_valid),
    .INSTR(instr),
    .WREG(wreg),
    .BUS_ADDR(bus_addr),
    .BUS_WDATA(bus_wdata),
    .BUS_WE(bus_we),
    .BUS_RE(bus_re),
    .BUS_RDATA(bus_rdata),
    .OPER(oper)
  );

  always #2.5 sys_clk = ~sys_clk;

  // ****************************************
  // access tasks
  // ****************************************
  task automatic check(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1)
    begin
      bad_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_we <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge sys_clk);
    bus_we <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    bus_re <= 1'b1;
    bus_addr <= a;
    @(posedge sys_clk);
    bus_re <= 1'b0;
    #1;
    check(bus_rdata === e, "register read");
  endtask : rd

  // mask bit 0 addresses, bit 1 destination flags, bit 2 literal
  task automatic issue(input logic [15:0] w, input logic [15:0] x, input logic [7:0] wv, input logic [2:0] m,
                       input dmag_pkg::dmag_oper_type e);
    @(posedge sys_clk);
    instr_valid <= 1'b1;
    instr <= '{word: w, ext: x};
    wreg <= wv;
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    #1;
    check(oper.valid === 1'b1 && oper.mode === e.mode, "operand mode");
    check(!m[0] || (oper.src === e.src && oper.dst === e.dst), "operand address");
    check(!m[1] || (oper.dest_w === e.dest_w && oper.wr_file === e.wr_file), "destination select");
    check(!m[2] || oper.lit === e.lit, "literal field");
    @(posedge sys_clk);
    #1;
    check(oper.valid === 1'b0, "valid pulse length");
  endtask : issue

  task automatic done_test(input string n);
    $display("test %s finished", n);
  endtask : done_test

  task automatic print_verdict;
    $display("comparisons %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 16; i++)
      rd(i[3:0], 8'h00);
    done_test("reset values");
    wr(4'h0, 8'hf5);
    wr(4'h9, 8'hff);
    rd(4'h0, 8'h05);
    rd(4'h9, 8'h00);
    done_test("register port");
    issue(16'h3334, 16'h0, 8'h0, 3'h3, {1'b1, 3'h2, 12'h534, 12'h534, 2'b01, 20'h0});
    issue(16'h3034, 16'h0, 8'h0, 3'h3, {1'b1, 3'h3, 12'h034, 12'h000, 2'b10, 20'h0});
    rd(4'h8, 8'h0b);
    issue(16'h305f, 16'h0, 8'h0, 3'h1, {1'b1, 3'h3, 12'h05f, 12'h000, 2'b10, 20'h0});
    issue(16'h3060, 16'h0, 8'h0, 3'h1, {1'b1, 3'h3, 12'hf60, 12'h000, 2'b10, 20'h0});
    issue(16'h4020, 16'h0, 8'h0, 3'h3, {1'b1, 3'h3, 12'h020, 12'h020, 2'b01, 20'h0});
    issue(16'h6110, 16'h0, 8'h0, 3'h3, {1'b1, 3'h2, 12'h510, 12'h510, 2'b01, 20'h0});
    issue(16'h7110, 16'h0, 8'h0, 3'h3, {1'b1, 3'h2, 12'h510, 12'h000, 2'b10, 20'h0});
    issue(16'h5123, 16'h0abc, 8'h0, 3'h3, {1'b1, 3'h6, 12'h123, 12'habc, 2'b01, 20'h0});
    done_test("direct addressing");
    issue(16'h1042, 16'h0, 8'h0, 3'h6, {1'b1, 3'h1, 24'h0, 2'b10, 20'h00042});
    issue(16'h2077, 16'h0abc, 8'h0, 3'h4, {1'b1, 3'h1, 26'h0, 20'habc77});
    issue(16'h0000, 16'h0, 8'h0, 3'h7, {1'b1, 49'h0});
    issue(16'h8334, 16'h0, 8'h0, 3'h7, {1'b1, 49'h0});
    done_test("inherent and literal");
    wr(4'h2, 8'ha0);
    wr(4'h3, 8'hf1);
    rd(4'h3, 8'h01);
    issue(16'h32d0, 16'h0, 8'h0, 3'h3, {1'b1, 3'h4, 12'h1a0, 12'h1a0, 2'b01, 20'h0});
    issue(16'h32d1, 16'h0, 8'h0, 3'h1, {1'b1, 3'h4, 12'h1a0, 12'h1a0, 22'h0});
    rd(4'h2, 8'ha1);
    issue(16'h32d2, 16'h0, 8'h0, 3'h1, {1'b1, 3'h4, 12'h1a1, 12'h1a1, 22'h0});
    rd(4'h2, 8'ha0);
    issue(16'h32d3, 16'h0, 8'h0, 3'h1, {1'b1, 3'h4, 12'h1a1, 12'h1a1, 22'h0});
    issue(16'h32d4, 16'h0, 8'hfe, 3'h1, {1'b1, 3'h4, 12'h19f, 12'h19f, 22'h0});
    rd(4'h2, 8'ha1);
    rd(4'h3, 8'h01);
    wr(4'h4, 8'hb0);
    wr(4'h5, 8'h02);
    issue(16'h32d8, 16'h0, 8'h0, 3'h1, {1'b1, 3'h4, 12'h2b0, 12'h2b0, 22'h0});
    done_test("indirect addressing");
    wr(4'h6, 8'h00);
    wr(4'h7, 8'h03);
    issue(16'h3005, 16'h0, 8'h0, 3'h1, {1'b1, 3'h3, 12'h005, 12'h000, 22'h0});
    wr(4'h1, 8'h01);
    rd(4'h1, 8'h01);
    issue(16'h3005, 16'h0, 8'h0, 3'h3, {1'b1, 3'h5, 12'h305, 12'h000, 2'b10, 20'h0});
    issue(16'h3080, 16'h0, 8'h0, 3'h1, {1'b1, 3'h3, 12'hf80, 12'h000, 22'h0});
    issue(16'h3305, 16'h0, 8'h0, 3'h1, {1'b1, 3'h2, 12'h505, 12'h505, 22'h0});
    wr(4'h1, 8'h00);
    issue(16'h3005, 16'h0, 8'h0, 3'h1, {1'b1, 3'h3, 12'h005, 12'h000, 22'h0});
    done_test("indexed addressing");
    wr(4'h0, 8'h0f);
    rd(4'h0, 8'h0f);
    issue(16'h33d0, 16'h0, 8'h0, 3'h3, {1'b1, 3'h4, 12'h1a1, 12'h1a1, 2'b01, 20'h0});
    issue(16'h32e0, 16'h0, 8'h0, 3'h3, {1'b1, 3'h4, 12'h300, 12'h300, 2'b01, 20'h0});
    done_test("banked and third pointer indirect");
    print_verdict();
  end

  // watchdog: the whole sequence needs well under 400 cycles
  initial
  begin
    #20000;
    bad_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    print_verdict();
  end
endmodule : tb_data_memory_address_generation
`default_nettype wire
